// *** design/ctc_capture_top.sv ***
// Purpose: Acquisition and trigger control with APB registers and readout.
// Assumes: PROBE is the comparator output, synchronous to CLOCK.
// Notes: EXT_CLK is sampled like data; its rising edge is the state-mode tick.
//
// What this block does
// R1 - Store one sample of all channels per sample period.
// R2 - Drive a software-set comparator threshold code.
// R3 - Capture memory holds a fixed depth of samples per channel.
// R4 - Four conditions, each up to sixteen sequential pattern levels.
// R5 - After trigger keep writing until memory is full, then stop.
// R6 - Trigger position splits memory into pre and post trigger parts.
// R7 - Without prefill, unwritten pre-trigger samples read back as zero.
// R8 - With prefill, trigger stays inactive until the pre region filled.
// R9 - Pass count 0 to 4095 skips that many qualifying events.
// R10 - Memory readable only after acquisition completes; host reads afterwards.
// R11 - External trigger input and trigger output for stacking.
// R12 - Pass counter reloads at start and counts qualifying events down.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module ctc_capture_top #(
  parameter int CH = ctc_pkg::CTC_CH,
  parameter int DEPTH = ctc_pkg::CTC_DEPTH,
  parameter int DIV_W = 32
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ctc_pkg::CTC_PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Probed target
  input wire logic [CH-1:0] PROBE,
  input wire logic EXT_CLK,
  // Stacking and analog front end
  input wire logic TRIG_IN,
  output logic TRIG_OUT,
  output logic [ctc_pkg::CTC_THR_W-1:0] THRESHOLD,
  // Interrupt
  output logic IRQ
);

  import ctc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(CTC_LEVELS);
  localparam logic [AW:0] DEPTH_V = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

  typedef struct packed {
    ctc_state_t st;
    logic [11:0] ctrl;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] div_cnt;
    logic [AW-1:0] pos;
    logic [CTC_PASS_W-1:0] pass_cfg;
    logic [CTC_PASS_W-1:0] pass_left;
    logic [CTC_THR_W-1:0] thr;
    logic [CH-1:0] lv_val;
    logic [CH-1:0] lv_mask;
    logic [5:0] lv_sel;
    logic lv_we;
    logic [15:0] lv_cnt;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] trig_addr;
    logic [AW-1:0] pre_valid;
    logic [AW-1:0] rd_index;
    logic [AW:0] wcount;
    logic [AW:0] post_left;
    logic ext_q;
    logic tin_q;
    logic arm;
    logic [1:0] ist;
    logic [1:0] imask;
    logic irq;
    logic tout;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctc_regs_t;

  ctc_regs_t s, n;
  logic tick, setup, wr, capt, qual, gate_open, zero_rd;
  logic [CTC_CONDS-1:0] hit;
  logic [CH-1:0] mem_q, rd_word;
  logic [AW:0] start_sum, phys_sum;
  logic [AW-1:0] start_addr, raddr;
  logic [1:0] ist_set, ist_clr;
  logic [31:0] rdat;
  logic rd_ok;

  // ----------------------------------------------------------------
  // Sample timing and capture datapath
  // ----------------------------------------------------------------
  // Internal mode ticks every DIV+1 clocks; state mode on each EXT_CLK rise.
  assign tick = s.ctrl[CTC_CTRL_EXT] ? (EXT_CLK & ~s.ext_q) : (s.div_cnt == s.div); // R1
  assign capt = tick & ((s.st == CTC_RUN) | (s.st == CTC_POST));

  ctc_sample_mem #(.W(CH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(CLOCK),
    .we(capt), // R1
    .waddr(s.wr_ptr),
    .wdata(PROBE),
    .raddr(raddr),
    .q(mem_q)
  );

  for (genvar g = 0; g < CTC_CONDS; g++) begin : g_cond
    ctc_trig_cond #(.CH(CH), .LEVELS(CTC_LEVELS)) u_cond (
      .clk(CLOCK),
      .rst_n(RST_N),
      .tick(tick & (s.st == CTC_RUN)),
      .arm(s.arm),
      .probe(PROBE),
      .cfg_we(s.lv_we && (s.lv_sel[5:4] == 2'(g))),
      .cfg_level(s.lv_sel[LW-1:0]),
      .cfg_val(s.lv_val),
      .cfg_mask(s.lv_mask),
      .last_level(s.lv_cnt[4*g +: 4]),
      .hit(hit[g])
    );
  end

  assign gate_open = ~s.ctrl[CTC_CTRL_PREFILL] | (s.wcount >= {1'b0, s.pos}); // R8
  assign qual = tick & gate_open & (s.st == CTC_RUN) &
                ((|(hit & s.ctrl[CTC_CTRL_COND +: CTC_CONDS])) |
                 (s.ctrl[CTC_CTRL_XTRIG] & TRIG_IN & ~s.tin_q)); // R11

  // ----------------------------------------------------------------
  // Readout address mapping
  // ----------------------------------------------------------------
  // The oldest pre-trigger location sits POS samples before the trigger.
  assign start_sum = {1'b0, s.trig_addr} + DEPTH_V - {1'b0, s.pos}; // R6
  assign start_addr = (start_sum >= DEPTH_V) ? AW'(start_sum - DEPTH_V) : start_sum[AW-1:0];
  // The read index is looked up from its next value so that the word is
  // ready by the setup cycle of a back-to-back transfer.
  assign phys_sum = {1'b0, start_addr} + {1'b0, n.rd_index};
  assign raddr = (phys_sum >= DEPTH_V) ? AW'(phys_sum - DEPTH_V) : phys_sum[AW-1:0];
  assign zero_rd = {1'b0, s.rd_index} < ({1'b0, s.pos} - {1'b0, s.pre_valid}); // R7
  assign rd_ok = (s.st == CTC_DONE); // R10
  assign rd_word = (rd_ok && !zero_rd) ? mem_q : '0; // R7

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & PWRITE & s.pready;

  always_comb begin
    rdat = 32'h0000_0000;
    unique case (PADDR)
      CTC_OFF_CTRL: rdat = {20'h00000, s.ctrl};
      CTC_OFF_STATUS: rdat = {4'h0, s.pass_left, 13'h0000, s.tout, s.st};
      CTC_OFF_DIV: rdat = 32'(s.div);
      CTC_OFF_POS: rdat = 32'(s.pos);
      CTC_OFF_PASS: rdat = 32'(s.pass_cfg);
      CTC_OFF_THR: rdat = 32'(s.thr);
      CTC_OFF_LVL_SEL: rdat = {26'h0000000, s.lv_sel};
      CTC_OFF_VAL_LO: rdat = s.lv_val[31:0];
      CTC_OFF_VAL_HI: rdat = 32'(s.lv_val[CH-1:32]);
      CTC_OFF_MASK_LO: rdat = s.lv_mask[31:0];
      CTC_OFF_MASK_HI: rdat = 32'(s.lv_mask[CH-1:32]);
      CTC_OFF_LVL_CNT: rdat = {16'h0000, s.lv_cnt};
      CTC_OFF_RD_IDX: rdat = 32'(s.rd_index);
      CTC_OFF_RD_LO: rdat = rd_word[31:0];
      CTC_OFF_RD_HI: rdat = 32'(rd_word[CH-1:32]);
      CTC_OFF_INT_ST: rdat = {30'h00000000, s.ist};
      CTC_OFF_INT_MASK: rdat = {30'h00000000, s.imask};
      default: rdat = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    ist_set = 2'b00;
    ist_clr = 2'b00;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.lv_we = 1'b0;
    n.arm = 1'b0;
    n.ext_q = EXT_CLK;
    n.div_cnt = (tick || s.ctrl[CTC_CTRL_EXT]) ? '0 : s.div_cnt + 1'b1; // R1
    if (tick) begin
      n.tin_q = TRIG_IN;
    end

    // Zero-wait APB: answer latched in setup, shown in the access cycle.
    if (setup) begin
      n.pready = 1'b1;
      n.prdata = rdat;
      n.pslverr = ((PADDR == CTC_OFF_RD_LO || PADDR == CTC_OFF_RD_HI) && !rd_ok) || // R10
                  (PADDR > CTC_OFF_INT_MASK) || (PADDR[1:0] != 2'b00);
    end

    // Capture sequence.
    if (capt) begin
      n.wr_ptr = (s.wr_ptr == LAST_ADDR) ? '0 : s.wr_ptr + 1'b1; // R1
    end
    unique case (s.st)
      CTC_IDLE, CTC_DONE: begin
      end
      CTC_RUN: begin
        if (tick && s.wcount < DEPTH_V) begin
          n.wcount = s.wcount + 1'b1;
        end
        if (qual) begin
          if (s.pass_left == '0) begin // R12
            n.trig_addr = s.wr_ptr;
            n.pre_valid = (s.wcount >= {1'b0, s.pos}) ? s.pos : s.wcount[AW-1:0]; // R7
            n.post_left = DEPTH_V - {1'b0, s.pos} - 1'b1; // R6
            n.tout = 1'b1; // R11
            ist_set[CTC_INT_TRIG] = 1'b1;
            if (n.post_left == '0) begin
              n.st = CTC_DONE; // R5
              ist_set[CTC_INT_DONE] = 1'b1;
            end else begin
              n.st = CTC_POST;
            end
          end else begin
            n.pass_left = s.pass_left - 1'b1; // R9
          end
        end
      end
      CTC_POST: begin
        if (tick) begin
          if (s.post_left == (AW + 1)'(1)) begin
            n.st = CTC_DONE; // R5
            ist_set[CTC_INT_DONE] = 1'b1;
          end
          n.post_left = s.post_left - 1'b1;
        end
      end
    endcase

    // Register writes.
    if (wr) begin
      unique case (PADDR)
        CTC_OFF_CTRL: begin
          n.ctrl = PWDATA[11:0] & CTC_CTRL_WMASK;
          if (PWDATA[CTC_CTRL_ABORT]) begin
            n.st = CTC_IDLE;
          end else if (PWDATA[CTC_CTRL_START]) begin
            n.st = CTC_RUN;
            n.wr_ptr = '0;
            n.wcount = '0;
            n.rd_index = '0;
            n.pass_left = s.pass_cfg; // R12
            n.tout = 1'b0;
            n.arm = 1'b1;
            n.div_cnt = '0;
          end
        end
        CTC_OFF_DIV: n.div = DIV_W'(PWDATA);
        CTC_OFF_POS: begin
          n.pos = ({1'b0, PWDATA[AW-1:0]} >= DEPTH_V) ? LAST_ADDR : PWDATA[AW-1:0]; // R6
        end
        CTC_OFF_PASS: n.pass_cfg = PWDATA[CTC_PASS_W-1:0]; // R9
        CTC_OFF_THR: n.thr = PWDATA[CTC_THR_W-1:0]; // R2
        CTC_OFF_LVL_SEL: begin
          n.lv_sel = PWDATA[5:0];
          n.lv_we = 1'b1; // R4
        end
        CTC_OFF_VAL_LO: n.lv_val[31:0] = PWDATA;
        CTC_OFF_VAL_HI: n.lv_val[CH-1:32] = PWDATA[CH-33:0];
        CTC_OFF_MASK_LO: n.lv_mask[31:0] = PWDATA;
        CTC_OFF_MASK_HI: n.lv_mask[CH-1:32] = PWDATA[CH-33:0];
        CTC_OFF_LVL_CNT: n.lv_cnt = PWDATA[15:0];
        CTC_OFF_RD_IDX: n.rd_index = ({1'b0, PWDATA[AW-1:0]} >= DEPTH_V) ? '0 : PWDATA[AW-1:0];
        CTC_OFF_INT_ST: ist_clr = PWDATA[1:0];
        CTC_OFF_INT_MASK: n.imask = PWDATA[1:0];
        default: begin
        end
      endcase
    end

    // Reading the high word steps to the next sample.
    if (PSEL && PENABLE && !PWRITE && s.pready && PADDR == CTC_OFF_RD_HI && rd_ok) begin // R10
      n.rd_index = (s.rd_index == LAST_ADDR) ? '0 : s.rd_index + 1'b1;
    end

    // A new event wins over a clear written in the same cycle.
    n.ist = (s.ist & ~ist_clr) | ist_set;
    n.irq = |(n.ist & n.imask);
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.thr <= CTC_THR_RST;
      s.lv_cnt <= CTC_LVL_CNT_RST;
    end else begin
      s <= n;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign TRIG_OUT = s.tout; // R11
  assign THRESHOLD = s.thr; // R2
  assign IRQ = s.irq;

endmodule
`default_nettype wire

// *** pkg/ctc_pkg.sv ***
// Purpose: Shared constants and types of the capture and trigger control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.

package ctc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CTC_CH = 36;
  localparam int CTC_DEPTH = 75497472;
  localparam int CTC_CONDS = 4;
  localparam int CTC_LEVELS = 16;
  localparam int CTC_PASS_W = 12;
  localparam int CTC_THR_W = 12;
  localparam int CTC_PADDR_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CTC_OFF_STATUS = 8'h04;
  localparam logic [7:0] CTC_OFF_DIV = 8'h08;
  localparam logic [7:0] CTC_OFF_POS = 8'h0c;
  localparam logic [7:0] CTC_OFF_PASS = 8'h10;
  localparam logic [7:0] CTC_OFF_THR = 8'h14;
  localparam logic [7:0] CTC_OFF_LVL_SEL = 8'h18;
  localparam logic [7:0] CTC_OFF_VAL_LO = 8'h1c;
  localparam logic [7:0] CTC_OFF_VAL_HI = 8'h20;
  localparam logic [7:0] CTC_OFF_MASK_LO = 8'h24;
  localparam logic [7:0] CTC_OFF_MASK_HI = 8'h28;
  localparam logic [7:0] CTC_OFF_LVL_CNT = 8'h2c;
  localparam logic [7:0] CTC_OFF_RD_IDX = 8'h30;
  localparam logic [7:0] CTC_OFF_RD_LO = 8'h34;
  localparam logic [7:0] CTC_OFF_RD_HI = 8'h38;
  localparam logic [7:0] CTC_OFF_INT_ST = 8'h3c;
  localparam logic [7:0] CTC_OFF_INT_MASK = 8'h40;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTC_CTRL_START = 0;
  localparam int CTC_CTRL_ABORT = 1;
  localparam int CTC_CTRL_EXT = 2;
  localparam int CTC_CTRL_PREFILL = 3;
  localparam int CTC_CTRL_XTRIG = 4;
  localparam int CTC_CTRL_COND = 8;
  localparam logic [11:0] CTC_CTRL_WMASK = 12'hf1c;
  localparam int CTC_INT_TRIG = 0;
  localparam int CTC_INT_DONE = 1;
  localparam logic [11:0] CTC_THR_RST = 12'h800;
  localparam logic [15:0] CTC_LVL_CNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    CTC_IDLE = 2'b00,
    CTC_RUN = 2'b01,
    CTC_POST = 2'b11,
    CTC_DONE = 2'b10
  } ctc_state_t;

endpackage

// *** design/ctc_sample_mem.sv ***
// Purpose: Capture memory, one word of all channels per sample.
// Assumes: One write port, one read port, read data one clock late.
// Notes: Contents are not reset; only written locations are ever shown.
`timescale 1ns/100ps
`default_nettype none

module ctc_sample_mem #(
  parameter int W = 36,
  parameter int DEPTH = 75497472,
  parameter int AW = 27
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] q
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata; // R3
    end
    q <= mem[raddr];
  end

endmodule
`default_nettype wire

// *** design/ctc_trig_cond.sv ***
// Purpose: One trigger condition, a chain of up to sixteen pattern levels.
// Assumes: Levels are programmed while no acquisition runs.
// Notes: Hit is combinational and marks the sample that completes the chain.
`timescale 1ns/100ps
`default_nettype none

module ctc_trig_cond
  import ctc_pkg::*;
#(
  parameter int CH = 36,
  parameter int LEVELS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sampling
  input wire logic tick,
  input wire logic arm,
  input wire logic [CH-1:0] probe,
  // Level programming
  input wire logic cfg_we,
  input wire logic [$clog2(LEVELS)-1:0] cfg_level,
  input wire logic [CH-1:0] cfg_val,
  input wire logic [CH-1:0] cfg_mask,
  input wire logic [$clog2(LEVELS)-1:0] last_level,
  // Result
  output logic hit
);

  localparam int LW = $clog2(LEVELS);

  typedef struct packed {
    logic [LEVELS-1:0][CH-1:0] val;
    logic [LEVELS-1:0][CH-1:0] mask;
    logic [LW-1:0] lvl;
  } ctc_cond_t;

  ctc_cond_t s, n;
  logic match;

  assign match = ((probe ^ s.val[s.lvl]) & s.mask[s.lvl]) == '0;
  assign hit = tick & match & (s.lvl == last_level); // R4

  always_comb begin
    n = s;
    if (cfg_we) begin
      n.val[cfg_level] = cfg_val;
      n.mask[cfg_level] = cfg_mask;
    end
    // A level is left only when its pattern matches; a miss holds the chain.
    if (arm) begin
      n.lvl = '0;
    end else if (tick && match) begin
      n.lvl = (s.lvl == last_level) ? '0 : s.lvl + 1'b1; // R4
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule
`default_nettype wire

// *** tb/ctc_asserts.sv ***
// Purpose: Port checks of the capture and trigger block.
// Assumes: Zero-wait APB slave, one clock domain.
// Notes: Sees only the top-level ports.
`timescale 1ns/100ps
`default_nettype none

module ctc_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ctc_pkg::CTC_PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Block outputs
  input wire logic TRIG_OUT,
  input wire logic [ctc_pkg::CTC_THR_W-1:0] THRESHOLD,
  input wire logic IRQ
);
  import ctc_pkg::*;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic acc;
  logic go;
  assign acc = PSEL && PENABLE && PREADY;
  // A start clears the trigger output, so it may only drop after a start or abort write.
  assign go = acc && PWRITE && PADDR == CTC_OFF_CTRL && PWDATA[1:0] != 2'b00;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence mask_off_s;
    acc && PWRITE && PADDR == CTC_OFF_INT_MASK && PWDATA == 32'h0;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> PREADY)
    else $error("ready missing after setup");
  ready_in_access_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  bad_addr_err_a: assert property (acc && (PADDR > 8'h40 || PADDR[1:0] != 2'b00) |-> PSLVERR)
    else $error("bad address accepted");
  thr_write_a: assert property (acc && PWRITE && PADDR == CTC_OFF_THR |=>
    {20'h0, THRESHOLD} == ($past(PWDATA) & 32'hfff)) else $error("threshold not written");
  trig_hold_a: assert property (TRIG_OUT && !go && !$past(go) |=> TRIG_OUT)
    else $error("trigger output dropped");
  irq_mask_a: assert property (mask_off_s |-> ##2 !IRQ)
    else $error("irq high with mask clear");
endmodule

bind ctc_capture_top ctc_asserts u_ctc_asserts (
  .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRIG_OUT(TRIG_OUT), .THRESHOLD(THRESHOLD), .IRQ(IRQ)
);
`default_nettype wire

// *** tb/ctc_target_model.sv ***
// Purpose: Probed target driving a running count on the probes.
// Assumes: Pins change just after the rising clock edge.
// Notes: The state-mode clock stands still unless enabled.
`timescale 1ns/100ps
`default_nettype none

module ctc_target_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic clr,
  input wire logic ext_en,
  // Target pins
  output logic [35:0] probe,
  output logic ext_clk
);
  logic [31:0] cnt;
  // A new value every clock lets each stored sample be told apart.
  assign probe = {cnt[3:0] ^ 4'ha, cnt};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0;
      ext_clk <= 1'b0;
    end else begin
      cnt <= clr ? 32'h0 : cnt + 32'h1;
      ext_clk <= ext_en ? !ext_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_capture_trigger_control.sv ***
// Purpose: Self-checking bench of the capture and trigger block.
// Assumes: Zero-wait APB, memory depth shortened to sixteen.
// Notes: Reads queue their expected answer; a monitor compares them.
`timescale 1ns/100ps
`default_nettype none

module tb_capture_trigger_control;
  import ctc_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} ctc_note_t;
  localparam int DEPTH = 16;
  logic CLOCK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic TRIG_IN = 1'b0, clr = 1'b1, ext_en = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, prev, lo_seen;
  logic PREADY, PSLVERR, EXT_CLK, TRIG_OUT, IRQ;
  logic [35:0] PROBE;
  logic [11:0] THRESHOLD;
  ctc_note_t nt;
  ctc_note_t notes[$];
  int err_count = 0, tests_run = 0;

  ctc_capture_top #(.DEPTH(DEPTH)) u_ctc_capture_top (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PROBE(PROBE), .EXT_CLK(EXT_CLK), .TRIG_IN(TRIG_IN), .TRIG_OUT(TRIG_OUT),
    .THRESHOLD(THRESHOLD), .IRQ(IRQ));
  ctc_target_model u_ctc_target_model (.clk(CLOCK), .rst_n(RST_N), .clr(clr),
    .ext_en(ext_en), .probe(PROBE), .ext_clk(EXT_CLK));

  initial begin
    forever #20 CLOCK = ~CLOCK;
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    check(32'h0, 32'h1, msg);
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ex, input logic [31:0] m, input logic e);
    int n;
    n = 0;
    if (!w) notes.push_back('{ex, m, e});
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) fail("ready timeout");
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m,
                     input logic e);
    apb(1'b0, a, 32'h0, ex, m, e);
  endtask
  // One sample word: low channels first, then the four high ones.
  task automatic rdp(input logic [31:0] lo, input logic [31:0] m, input logic [3:0] hi);
    rdc(CTC_OFF_RD_LO, lo, m, 1'b0);
    lo_seen = rd;
    rdc(CTC_OFF_RD_HI, {28'h0, hi}, {28'h0, m[3:0]}, 1'b0);
  endtask
  task automatic run(input logic [31:0] pos, input logic [31:0] pass, input logic [31:0] ctrl);
    int n;
    n = 0;
    wr(CTC_OFF_POS, pos);
    wr(CTC_OFF_PASS, pass);
    clr <= 1'b1;
    wr(CTC_OFF_CTRL, ctrl);
    clr <= 1'b0;
    do begin
      rdc(CTC_OFF_STATUS, 32'h0, 32'h0, 1'b0);
      n++;
    end while (rd[1:0] !== 2'b10 && n < 200);
    if (rd[1:0] !== 2'b10) fail("done timeout");
    rdc(CTC_OFF_STATUS, 32'h6, 32'h0fff0007, 1'b0);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge CLOCK);
    #1;
    check({31'h0, IRQ}, {31'h0, v}, "irq level");
  endtask

  always @(posedge CLOCK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
      if (notes.size() == 0) begin
        check(32'h0, 32'h1, "read without note");
      end else begin
        nt = notes.pop_front();
        check(PRDATA & nt.m, nt.d & nt.m, "read data");
        check({31'h0, PSLVERR}, {31'h0, nt.e}, "slave error");
      end
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(32'h74d52674);
    repeat (16) @(posedge CLOCK);
    RST_N <= 1'b1;
    @(posedge CLOCK);
    #1;
    check({20'h0, THRESHOLD}, {20'h0, CTC_THR_RST}, "threshold reset");
    rdc(CTC_OFF_LVL_CNT, {16'h0, CTC_LVL_CNT_RST}, 32'hffff, 1'b0);
    prev = $urandom;
    wr(CTC_OFF_THR, prev);
    @(posedge CLOCK);
    #1;
    check({20'h0, THRESHOLD}, prev & 32'hfff, "threshold set");
    rdc(CTC_OFF_THR, prev, 32'hfff, 1'b0);
    rdc(CTC_OFF_RD_LO, 32'h0, 32'hffffffff, 1'b1);
    rdc(8'h44, 32'h0, 32'h0, 1'b1);
    rdc(8'h06, 32'h0, 32'h0, 1'b1);
    $display("test idle done");
    wr(CTC_OFF_VAL_LO, 32'h8);
    wr(CTC_OFF_VAL_HI, 32'h0);
    wr(CTC_OFF_MASK_LO, 32'hf);
    wr(CTC_OFF_MASK_HI, 32'h0);
    wr(CTC_OFF_LVL_SEL, 32'h0);
    // Two skipped matches put the trigger on count 40, four samples in.
    run(32'h4, 32'h2, 32'h101);
    wr(CTC_OFF_RD_IDX, 32'h0);
    for (int i = 0; i <= DEPTH; i++) begin
      prev = 32'd36 + 32'(i % DEPTH);
      rdp(prev, 32'hffffffff, prev[3:0] ^ 4'ha);
    end
    rdc(CTC_OFF_INT_ST, 32'h3, 32'h3, 1'b0);
    irq_is(1'b0);
    wr(CTC_OFF_INT_MASK, 32'h2);
    irq_is(1'b1);
    wr(CTC_OFF_INT_ST, 32'h3);
    irq_is(1'b0);
    wr(CTC_OFF_INT_MASK, 32'h0);
    $display("test capture done");
    wr(CTC_OFF_LVL_SEL, 32'h10);
    wr(CTC_OFF_VAL_LO, 32'h9);
    wr(CTC_OFF_LVL_SEL, 32'h11);
    wr(CTC_OFF_LVL_CNT, 32'h10);
    run(32'hc, 32'h0, 32'h201);
    wr(CTC_OFF_RD_IDX, 32'h0);
    for (int i = 0; i < 3; i++) rdp(32'h0, 32'hffffffff, 4'h0);
    wr(CTC_OFF_RD_IDX, 32'hb);
    rdp(32'h8, 32'hffffffff, 4'h2);
    rdp(32'h9, 32'hffffffff, 4'h3);
    run(32'hc, 32'h0, 32'h109);
    wr(CTC_OFF_RD_IDX, 32'h0);
    rdp(32'hc, 32'hffffffff, 4'h6);
    wr(CTC_OFF_RD_IDX, 32'hc);
    rdp(32'h18, 32'hffffffff, 4'h2);
    $display("test levels done");
    // A divider of two samples every third count: 2, 5, then the trigger on 8.
    wr(CTC_OFF_DIV, 32'h2);
    run(32'h4, 32'h0, 32'h101);
    wr(CTC_OFF_RD_IDX, 32'h3);
    rdp(32'h5, 32'hffffffff, 4'hf);
    rdp(32'h8, 32'hffffffff, 4'h2);
    // With no condition enabled the run only ends by abort.
    wr(CTC_OFF_CTRL, 32'h1);
    rdc(CTC_OFF_STATUS, 32'h1, 32'h3, 1'b0);
    wr(CTC_OFF_CTRL, 32'h2);
    rdc(CTC_OFF_STATUS, 32'h0, 32'h3, 1'b0);
    rdc(CTC_OFF_RD_LO, 32'h0, 32'hffffffff, 1'b1);
    $display("test rate done");
    ext_en <= 1'b1;
    fork
      run(32'h4, 32'h0, 32'h15);
      begin
        repeat (40) @(posedge CLOCK);
        TRIG_IN <= 1'b1;
      end
    join
    check({31'h0, TRIG_OUT}, 32'h1, "trigger out");
    wr(CTC_OFF_RD_IDX, 32'h4);
    rdp(32'h0, 32'h0, 4'h0);
    prev = lo_seen;
    rdp(32'h0, 32'h0, 4'h0);
    check(lo_seen - prev, 32'h2, "state mode spacing");
    $display("test state done");
    print_verdict();
  end
endmodule
`default_nettype wire
